// ===== rsw_cfg.svh
`ifndef RSW_CFG_SVH
`define RSW_CFG_SVH
`define RSW_CTRL_RESET   16'hffff
`define RSW_MODE_STANDBY 2'h0
`define RSW_MODE_INPUT   2'h1
`define RSW_MODE_ON      2'h2
`define RSW_MODE_OFF     2'h3
`define RSW_WORD_BITS    16
`define RSW_BYTE_BITS    8
`endif

// ===== rsw_pkg.sv
package rsw_pkg;
   typedef enum logic [2:0]
   {
      RSW_IDLE   = 3'b001,
      RSW_ACTIVE = 3'b010,
      RSW_SLEEP  = 3'b100
   } rsw_state_e;

   typedef struct packed {
      logic [15:0] control;
      logic [15:0] shifter;
      logic [5:0]  clk_count;
      logic        error_flag;
      logic        so_data;
      logic        so_oe_b;
      logic        in_frame;
      logic        first_edge_seen;
      rsw_state_e  state;
   } rsw_spi_s;

   typedef struct packed {
      logic open_load;
      logic fault;
   } rsw_diag_s;
endpackage : rsw_pkg

// ===== rsw_channel.sv
`timescale 1ns/1ps
`include "rsw_cfg.svh"
module rsw_channel
   import rsw_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic [1:0] i_mode,
   input  wire logic       i_in_pin,
   input  wire logic       i_open_load,
   input  wire logic       i_overload,
   output logic            o_on,
   output logic            o_diag_current,
   output rsw_diag_s       o_diag
);
   typedef struct packed {
      logic      on;
      logic      diag_current;
      rsw_diag_s diag;
   } rsw_chan_s;

   rsw_chan_s chan_reg;
   rsw_chan_s chan_next;

   // Mode decode; flags stick until standby clears them
   always_comb
   begin
      chan_next = chan_reg;
      unique case (i_mode)
         `RSW_MODE_STANDBY:
         begin
            chan_next.on = 1'b0;
            chan_next.diag_current = 1'b0;
            chan_next.diag = '0;
         end
         `RSW_MODE_INPUT:
         begin
            chan_next.on = i_in_pin & ~i_overload;
            chan_next.diag_current = ~i_in_pin;
         end
         `RSW_MODE_ON:
         begin
            chan_next.on = ~i_overload;
            chan_next.diag_current = 1'b0;
         end
         `RSW_MODE_OFF:
         begin
            chan_next.on = 1'b0;
            chan_next.diag_current = 1'b1;
         end
      endcase
      if (i_mode != `RSW_MODE_STANDBY)
      begin
         // Open load only judged while off, overload only while on
         if (i_open_load && !chan_reg.on)
            chan_next.diag.open_load = 1'b1;
         if (i_overload && chan_reg.on)
         begin
            chan_next.diag.fault = 1'b1;
            chan_next.on = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         chan_reg <= '0;
      else
         chan_reg <= chan_next;
   end

   assign o_on           = chan_reg.on;
   assign o_diag_current = chan_reg.diag_current;
   assign o_diag         = chan_reg.diag;

   AST_STANDBY_CLEARS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_mode == `RSW_MODE_STANDBY |=> !chan_reg.diag.open_load && !chan_reg.diag.fault
         && !chan_reg.on) else $error("standby did not clear channel");
   AST_FORCED_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_mode == `RSW_MODE_OFF |=> !chan_reg.on) else $error("forced off channel is on");
   AST_FLAG_STICKS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      chan_reg.diag.fault && i_mode != `RSW_MODE_STANDBY |=> chan_reg.diag.fault)
      else $error("fault flag dropped");
endmodule : rsw_channel

// ===== rsw_spi_slave.sv
`timescale 1ns/1ps
`include "rsw_cfg.svh"
module rsw_spi_slave
   import rsw_pkg::*;
#(
   parameter int CHANNELS  = 8,
   parameter int WORD_BITS = `RSW_WORD_BITS
)
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_cs_b,
   input  wire logic       i_sclk,
   input  wire logic       i_si,
   input  wire logic [7:0] i_in_pins,
   input  wire logic [7:0] i_open_load,
   input  wire logic [7:0] i_overload,
   output logic            o_so,
   output logic            o_so_oe_b,
   output logic [7:0]      o_chan_on,
   output logic [7:0]      o_diag_current,
   output logic            o_sleep,
   output logic [15:0]     o_control
);
   rsw_spi_s   spi_reg;
   rsw_spi_s   spi_next;
   logic [2:0] cs_sync_reg;
   logic [2:0] sclk_sync_reg;
   logic [1:0] si_sync_reg;
   logic [2:0] in_sync_reg [0:7];
   logic [7:0] ol_sync_reg [0:1];
   logic [7:0] ovl_sync_reg [0:1];
   logic [7:0] in_pins_s;
   logic [7:0] chan_on_w;
   logic [7:0] diag_cur_w;
   rsw_diag_s  diag_w [0:7];
   logic [15:0] diag_word;
   logic [7:0] chan_on_reg;
   logic [7:0] diag_cur_reg;
   logic       cs_fall;
   logic       cs_rise;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_low;
   logic       valid_len;

   // Pins, mode fields and diagnosis word are laid out for eight channels of 16 bits only
   generate
      if (CHANNELS != 8 || WORD_BITS != 16)
      begin : g_bad_size
         $error("rsw_spi_slave serves eight channels and a 16-bit word only");
      end
   endgenerate

   // Two-stage synchronisers; stage one feeds only stage two
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cs_sync_reg   <= 3'h7;
         sclk_sync_reg <= 3'h0;
         si_sync_reg   <= 2'h0;
         ol_sync_reg   <= '{default: 8'h00};
         ovl_sync_reg  <= '{default: 8'h00};
      end
      else
      begin
         cs_sync_reg   <= {cs_sync_reg[1:0], i_cs_b};
         sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
         si_sync_reg   <= {si_sync_reg[0], i_si};
         ol_sync_reg   <= '{i_open_load, ol_sync_reg[0]};
         ovl_sync_reg  <= '{i_overload, ovl_sync_reg[0]};
      end
   end

   // Edge detect uses stages two and three only
   assign cs_low    = ~cs_sync_reg[1];
   assign cs_fall   = cs_sync_reg[2] & ~cs_sync_reg[1];
   assign cs_rise   = ~cs_sync_reg[2] & cs_sync_reg[1];
   assign sclk_rise = ~sclk_sync_reg[2] & sclk_sync_reg[1];
   assign sclk_fall = sclk_sync_reg[2] & ~sclk_sync_reg[1];
   assign valid_len = (spi_reg.clk_count[2:0] == 3'h0)
                      && (spi_reg.clk_count >= 6'(WORD_BITS));

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : g_chan
         always_ff @(posedge i_clk or negedge i_rst_b)
         begin
            if (!i_rst_b)
               in_sync_reg[g] <= 3'h0;
            else
               in_sync_reg[g] <= {in_sync_reg[g][1:0], i_in_pins[g]};
         end
         assign in_pins_s[g] = in_sync_reg[g][1];
         rsw_channel u_chan (
            .i_clk          (i_clk),
            .i_rst_b        (i_rst_b),
            .i_mode         (spi_reg.control[2*g+1:2*g]),
            .i_in_pin       (in_pins_s[g]),
            .i_open_load    (ol_sync_reg[1][g]),
            .i_overload     (ovl_sync_reg[1][g]),
            .o_on           (chan_on_w[g]),
            .o_diag_current (diag_cur_w[g]),
            .o_diag         (diag_w[g])
         );
         assign diag_word[2*g+1] = diag_w[g].open_load;
         assign diag_word[2*g]   = diag_w[g].fault;
      end
   endgenerate

   // Serial protocol; count folds back from 56 to 49, keeping its low three bits, so long chains stay legal
   always_comb
   begin
      spi_next = spi_reg;
      if (cs_fall)
      begin
         spi_next.in_frame        = 1'b1;
         spi_next.shifter         = diag_word;
         spi_next.clk_count       = 6'h00;
         spi_next.first_edge_seen = 1'b0;
         spi_next.so_oe_b         = 1'b0;
         spi_next.so_data         = spi_reg.error_flag | si_sync_reg[1];
      end
      else if (spi_reg.in_frame && cs_low)
      begin
         if (!spi_reg.first_edge_seen)
            spi_next.so_data = spi_reg.error_flag | si_sync_reg[1];
         if (sclk_rise)
         begin
            spi_next.first_edge_seen = 1'b1;
            spi_next.so_data         = spi_reg.shifter[15];
         end
         if (sclk_fall)
         begin
            spi_next.shifter = {spi_reg.shifter[14:0], si_sync_reg[1]};
            if (spi_reg.clk_count[5:3] != 3'h7)
               spi_next.clk_count = spi_reg.clk_count + 6'h01;
            else
               spi_next.clk_count = {3'h6, spi_reg.clk_count[2:0] + 3'h1};
         end
      end
      if (cs_rise && spi_reg.in_frame)
      begin
         spi_next.in_frame = 1'b0;
         spi_next.so_oe_b  = 1'b1;
         spi_next.error_flag = ~valid_len;
         if (valid_len)
            spi_next.control = spi_reg.shifter;
      end
      if (!cs_low && !cs_fall)
         spi_next.so_oe_b = 1'b1;
      spi_next.state = (spi_next.control == 16'h0000) ? RSW_SLEEP
                     : (spi_next.control == `RSW_CTRL_RESET) ? RSW_IDLE : RSW_ACTIVE;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         spi_reg.control         <= `RSW_CTRL_RESET;
         spi_reg.shifter         <= 16'h0000;
         spi_reg.clk_count       <= 6'h00;
         spi_reg.error_flag      <= 1'b1;
         spi_reg.so_data         <= 1'b0;
         spi_reg.so_oe_b         <= 1'b1;
         spi_reg.in_frame        <= 1'b0;
         spi_reg.first_edge_seen <= 1'b0;
         spi_reg.state           <= RSW_IDLE;
         chan_on_reg             <= 8'h00;
         diag_cur_reg            <= 8'h00;
      end
      else
      begin
         spi_reg      <= spi_next;
         chan_on_reg  <= chan_on_w;
         diag_cur_reg <= diag_cur_w;
      end
   end

   assign o_so           = spi_reg.so_data;
   assign o_so_oe_b      = spi_reg.so_oe_b;
   assign o_chan_on      = chan_on_reg;
   assign o_diag_current = diag_cur_reg;
   assign o_sleep        = spi_reg.state[2]; // One-hot sleep bit, straight from its flop
   assign o_control      = spi_reg.control;

   sequence s_frame_end;
      $rose(cs_sync_reg[1]) ##1 1'b1;
   endsequence

   AST_RELEASE_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_sync_reg[1] && cs_sync_reg[2] |=> o_so_oe_b) else $error("so driven while idle");
   AST_LOAD_DIAG: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_fall |=> spi_reg.shifter == $past(diag_word) && !o_so_oe_b)
      else $error("diag not loaded");
   AST_ERR_OUT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_fall |=> o_so == ($past(spi_reg.error_flag) | $past(si_sync_reg[1])))
      else $error("error bit wrong on so");
   AST_COMMIT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_rise && spi_reg.in_frame && valid_len |=> o_control == $past(spi_reg.shifter)
      && !spi_reg.error_flag) else $error("valid word not committed");
   AST_REJECT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_rise && spi_reg.in_frame && !valid_len |=> $stable(o_control)
      && spi_reg.error_flag) else $error("invalid word taken");
   AST_SHIFT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      spi_reg.in_frame && cs_low && sclk_fall && !cs_rise |=>
      spi_reg.shifter[0] == $past(si_sync_reg[1])) else $error("shift wrong");
   AST_MSB_OUT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      spi_reg.in_frame && cs_low && sclk_rise && !cs_fall && !cs_rise |=>
      o_so == $past(spi_reg.shifter[15])) else $error("msb not shifted out");
   AST_SLEEP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_control == 16'h0000 |-> o_sleep) else $error("no sleep at all standby");
   AST_END_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      s_frame_end |-> o_so_oe_b) else $error("so not released after frame");
endmodule : rsw_spi_slave

// ===== rsw_host_model.sv
`timescale 1ns/1ps
// Host master model: drives select, serial clock and data from the system clock
module rsw_host_model
(
   input  wire logic i_clk,
   input  wire logic i_so,
   input  wire logic i_so_oe_b,
   output logic      o_cs_b,
   output logic      o_sclk,
   output logic      o_si
);
   logic       oe_bad = 1'b0;
   logic [3:0] hi_n   = 4'h0;

   // Data line rests at its pull-down level between transfers
   initial
   begin
      o_cs_b = 1'b1;
      o_sclk = 1'b0;
      o_si   = 1'b0;
   end

   // Output must be released once select has settled high; sync delay is allowed for
   always @(posedge i_clk)
   begin
      hi_n <= o_cs_b ? ((hi_n == 4'hf) ? hi_n : hi_n + 4'h1) : 4'h0;
      if (hi_n > 4'h6 && i_so_oe_b !== 1'b1)
         oe_bad <= 1'b1;
   end

   // One frame of n clocks; sel low keeps select high so the clocks must be ignored
   task automatic xfer(input int n, input logic [31:0] d, input logic sel,
                       input logic si0, output logic [31:0] rx, output logic transfer_error_flag);
      rx = 32'h0;
      @(posedge i_clk);
      o_cs_b <= ~sel;
      o_si   <= si0;
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
      transfer_error_flag = i_so;
      @(posedge i_clk);
      // Each level held four cycles so the slave's synchroniser sees every edge
      for (int i = n - 1; i >= 0; i--)
      begin
         o_sclk <= 1'b1;
         o_si   <= d[i];
         repeat (3) @(posedge i_clk);
         @(negedge i_clk);
         rx = {rx[30:0], i_so};
         @(posedge i_clk);
         o_sclk <= 1'b0;
         repeat (4) @(posedge i_clk);
      end
      o_cs_b <= 1'b1;
      o_si   <= 1'b0;
      repeat (6) @(posedge i_clk);
   endtask : xfer
endmodule : rsw_host_model

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic        i_clk, i_rst_b, cs_b, sclk, si, so, so_oe_b, sleep, transfer_error_flag, s;
   logic [7:0]  pins, ol, ovl, on, dcur, p, e;
   logic [15:0] ctrl, c;
   logic [31:0] rx;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          lens [3]   = '{12, 8, 24};
   // Rows: control word, pins, expected channel outputs, expected sleep
   logic [32:0] rows [7]   = '{{16'h1b1b, 8'h00, 8'h22, 1'b0}, {16'h1b1b, 8'hff, 8'h66, 1'b0},
                               {16'he4e4, 8'h02, 8'h46, 1'b0}, {16'h5555, 8'ha5, 8'ha5, 1'b0},
                               {16'h0000, 8'h00, 8'h00, 1'b1}, {16'haaaa, 8'h00, 8'hff, 1'b0},
                               {16'hffff, 8'h00, 8'h00, 1'b0}};
   // No pull on the output, so a released line reads as unknown and never matches
   wire         so_w = so_oe_b ? 1'bz : so;

   rsw_host_model host
   (
      .i_clk     (i_clk),
      .i_so      (so_w),
      .i_so_oe_b (so_oe_b),
      .o_cs_b    (cs_b),
      .o_sclk    (sclk),
      .o_si      (si)
   );

   rsw_spi_slave dut
   (
      .i_clk          (i_clk),
      .i_rst_b        (i_rst_b),
      .i_cs_b         (cs_b),
      .i_sclk         (sclk),
      .i_si           (si),
      .i_in_pins      (pins),
      .i_open_load    (ol),
      .i_overload     (ovl),
      .o_so           (so),
      .o_so_oe_b      (so_oe_b),
      .o_chan_on      (on),
      .o_diag_current (dcur),
      .o_sleep        (sleep),
      .o_control      (ctrl)
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask : settle

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   // Clock generator
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // Sixteen frames of about 150 cycles are expected; a hang runs far past that
   initial
   begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      end_sim();
   end

   // Main sequence
   initial
   begin
      i_rst_b = 1'b0;
      pins    = 8'h00;
      ol      = 8'h00;
      ovl     = 8'h00;
      settle(12);
      chk(ctrl, 16'hffff, "rst ctrl");
      chk({so_oe_b, sleep, on}, 16'h0200, "rst out");
      @(posedge i_clk);
      i_rst_b <= 1'b1;
      settle(4);
      $display("reset test done");
      for (int r = 0; r < 7; r++)
      begin
         {c, p, e, s} = rows[r];
         @(posedge i_clk);
         pins <= p;
         host.xfer(16, {16'h0, c}, 1'b1, 1'b0, rx, transfer_error_flag);
         chk(transfer_error_flag, r == 0, "ter");
         settle(10);
         chk(ctrl, c, "ctrl");
         chk(on, e, "on");
         chk(sleep, s, "sleep");
         for (int g = 0; g < 8; g++)
            if (c[2*g+:2] == 2'h0 || (c[2*g+:2] == 2'h1 && !p[g]))
               chk(dcur[g], c[2*g+:2] == 2'h1, "dcur");
         $display("row %0d done", r);
      end
      // Short, unaligned and chained frames
      foreach (lens[k])
      begin
         host.xfer(lens[k], 32'h00a5_1b1b, 1'b1, 1'b0, rx, transfer_error_flag);
         chk(transfer_error_flag, k != 0, "len ter");
         settle(6);
         chk(ctrl, (lens[k] == 24) ? 16'h1b1b : 16'hffff, "len ctrl");
      end
      host.xfer(16, 32'h1b1b, 1'b1, 1'b1, rx, transfer_error_flag);
      chk(transfer_error_flag, 1'b1, "or si");
      $display("length test done");
      // Flags latch while detectors pulse during an unselected frame
      @(posedge i_clk);
      ol  <= 8'h01;
      ovl <= 8'h20;
      host.xfer(16, 32'h5a5a, 1'b0, 1'b0, rx, transfer_error_flag);
      settle(2);
      chk(ctrl, 16'h1b1b, "ignored");
      @(posedge i_clk);
      ol  <= 8'h00;
      ovl <= 8'h00;
      host.xfer(16, 32'h1b18, 1'b1, 1'b0, rx, transfer_error_flag);
      chk(transfer_error_flag, 1'b0, "ter");
      chk(rx[15:0], 16'h0402, "diag");
      host.xfer(16, 32'h1318, 1'b1, 1'b0, rx, transfer_error_flag);
      chk(rx[15:0], 16'h0400, "latch");
      host.xfer(16, 32'h0000, 1'b1, 1'b0, rx, transfer_error_flag);
      chk(rx[15:0], 16'h0000, "clear");
      $display("diag test done");
      // Reset in mid-run from sleep
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      settle(3);
      chk(ctrl, 16'hffff, "rst2 ctrl");
      chk({so_oe_b, sleep}, 16'h0002, "rst2 out");
      @(posedge i_clk);
      i_rst_b <= 1'b1;
      settle(4);
      host.xfer(16, 32'hffff, 1'b1, 1'b0, rx, transfer_error_flag);
      chk(transfer_error_flag, 1'b1, "ter rst");
      chk(host.oe_bad, 1'b0, "release");
      $display("mid reset test done");
      end_sim();
   end
endmodule : tb_top
